/* File: core/msrr_pkg.sv */
// constants, field layout and carriers for the meter status and result registers
// assumes one device clock; register numbers are word indices on the internal register port
package msrr_pkg;
	localparam int unsigned DATA_W = 24;
	localparam int unsigned ADDR_W = 5;
	// register indices
	localparam logic [4:0] ADDR_CYCLE_COUNT = 5'h05;
	localparam logic [4:0] ADDR_AVG_POWER = 5'h0A;
	localparam logic [4:0] ADDR_I_RMS = 5'h0B;
	localparam logic [4:0] ADDR_V_RMS = 5'h0C;
	localparam logic [4:0] ADDR_POWER_BIAS = 5'h0E;
	localparam logic [4:0] ADDR_EVENT_FLAGS = 5'h0F;
	localparam logic [4:0] ADDR_EVENT_ENABLE = 5'h1A;
	// reset values
	localparam logic [23:0] RST_CYCLE_COUNT = 24'h000FA0;
	localparam logic [23:0] RST_POWER_BIAS = 24'h000000;
	localparam logic [23:0] RST_EVENT_FLAGS = 24'h000001;
	localparam logic [23:0] RST_EVENT_ENABLE = 24'h000000;
	// flag positions
	localparam int unsigned BIT_CYCLE_DONE = 23;
	localparam int unsigned BIT_SAMPLE_DONE = 20;
	localparam int unsigned BIT_I_INST_OVF = 17;
	localparam int unsigned BIT_V_INST_OVF = 16;
	localparam int unsigned BIT_I_RMS_OVF = 14;
	localparam int unsigned BIT_V_RMS_OVF = 13;
	localparam int unsigned BIT_POWER_OVF = 12;
	localparam int unsigned BIT_TEMP_NEW = 7;
	localparam int unsigned BIT_TEMP_OSC = 6;
	localparam int unsigned BIT_V_OSC = 4;
	localparam int unsigned BIT_I_OSC = 3;
	localparam int unsigned BIT_SUPPLY_LOW = 2;
	localparam int unsigned BIT_VOLTAGE_DIP = 1;
	localparam int unsigned BIT_BAD_COMMAND_N = 0;
	localparam logic [23:0] FLAG_IMPL_MASK = 24'h9370DF;
	// bit 0 counts as raised while low
	localparam logic [23:0] FLAG_LOW_ACTIVE = 24'h000001;
	// interrupt pin styles
	localparam logic [1:0] IRQ_LEVEL_LOW = 2'h0;
	localparam logic [1:0] IRQ_LEVEL_HIGH = 2'h1;
	localparam logic [1:0] IRQ_PULSE_FALL = 2'h2;
	localparam logic [1:0] IRQ_PULSE_RISE = 2'h3;
	localparam logic [3:0] IRQ_PULSE_CYCLES = 4'h8;
	// accumulator and engine widths
	localparam int unsigned PACC_W = 49;
	localparam int unsigned SQACC_W = 71;
	localparam int unsigned DIV_W = 72;
	localparam int unsigned MS_W = 48;
	localparam logic [6:0] DIV_STEPS = 7'h48;
	localparam logic [6:0] SQRT_STEPS = 7'h18;

	typedef struct packed {
		logic valid;
		logic [23:0] current;
		logic [23:0] voltage;
		logic [23:0] power;
	} msrr_sample_s;

	typedef enum {ST_IDLE, ST_P_DIV, ST_I_DIV, ST_I_SQRT, ST_V_DIV, ST_V_SQRT} msrr_state_e;
endpackage

/* File: core/msrr_meter_status_result_regs.sv */
// status flags, interrupt mask, cycle averaging and rms results of the meter core
// assumes a command engine drives the register port and a datapath delivers samples on core_clk
// Notes on behaviour
// - active power is the signed mean of power samples over each cycle of n conversions
// - current and voltage rms computed once per cycle, unsigned fraction below one
// - power bias added to every power sample that is accumulated; resets to zero
// - reset leaves only flag bit 0 set and the whole enable register clear
// - writing one to a flag clears it; written zeros leave flags alone
// - interrupt is active while any raised flag has its enable bit set
// - bit 23 set when the engine writes a cycle's results during conversions and when calibration finishes
// - bit 20 set whenever a new conversion sample arrives
// - bit 17 on instantaneous current overflow, bit 16 on instantaneous voltage overflow
// - bit 14 current rms overflow, bit 13 voltage rms overflow, bit 12 power overflow
// - bit 7 set whenever the temperature result updates
// - bits 6, 4, 3 set on temperature, voltage, current modulator oscillation
// - persisting overload sets its oscillation flag again after every clear
// - bit 2 set on low supply; clears ignored until supply rises above high threshold
// - bit 1 set on voltage dip event
// - bit 0 normally one; driven low on bad command or failed status read
// - flags decoded at register 15, enable at register 26, both 24 bits
// - pin style: 00 low level, 01 high level, 10 falling pulse, 11 rising pulse
// - cycle length in conversions taken from cycle count register, reset 4000
`timescale 1ns/1ps
module msrr_meter_status_result_regs
	import msrr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	input wire msrr_sample_s sample,
	input wire logic conversions_on,
	input wire logic calibration_done,
	input wire logic temperature_update,
	input wire logic current_inst_overflow,
	input wire logic voltage_inst_overflow,
	input wire logic temp_modulator_oscillation,
	input wire logic voltage_modulator_oscillation,
	input wire logic current_modulator_oscillation,
	input wire logic supply_low_threshold,
	input wire logic supply_high_threshold,
	input wire logic voltage_dip_event,
	input wire logic bad_command,
	input wire logic status_read_fail,
	input wire logic [1:0] irq_style_sel,
	output logic irq_pin,
	output logic [DATA_W-1:0] averaged_power,
	output logic [DATA_W-1:0] current_root_mean_square,
	output logic [DATA_W-1:0] voltage_root_mean_square
);

	// ************************************************
	// register file
	// ************************************************
	logic [23:0] cycle_count;
	logic [23:0] power_bias;
	logic [23:0] event_flags;
	logic [23:0] event_enable;

	wire wr_cycle = reg_wr && (reg_addr == ADDR_CYCLE_COUNT);
	wire wr_bias = reg_wr && (reg_addr == ADDR_POWER_BIAS);
	wire wr_flags = reg_wr && (reg_addr == ADDR_EVENT_FLAGS);
	wire wr_enable = reg_wr && (reg_addr == ADDR_EVENT_ENABLE);

	logic [23:0] rd_mux;
	always_comb
	begin
		unique case (reg_addr)
			ADDR_CYCLE_COUNT: rd_mux = cycle_count;
			ADDR_AVG_POWER: rd_mux = averaged_power;
			ADDR_I_RMS: rd_mux = current_root_mean_square;
			ADDR_V_RMS: rd_mux = voltage_root_mean_square;
			ADDR_POWER_BIAS: rd_mux = power_bias;
			ADDR_EVENT_FLAGS: rd_mux = event_flags;
			ADDR_EVENT_ENABLE: rd_mux = event_enable;
			default: rd_mux = 24'h000000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cycle_count <= RST_CYCLE_COUNT;
			power_bias <= RST_POWER_BIAS;
			event_enable <= RST_EVENT_ENABLE;
			reg_rdata <= 24'h000000;
		end
		else
		begin
			if (wr_cycle)
				cycle_count <= reg_wdata;
			if (wr_bias)
				power_bias <= reg_wdata;
			if (wr_enable)
				event_enable <= reg_wdata & FLAG_IMPL_MASK;
			reg_rdata <= rd_mux;
		end
	end

	// ************************************************
	// supply comparator synchronisers
	// ************************************************
	logic [1:0] low_sync;
	logic [1:0] high_sync;
	logic supply_rearmed;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			low_sync <= 2'h0;
			high_sync <= 2'h0;
		end
		else
		begin
			low_sync <= {low_sync[0], supply_low_threshold};
			high_sync <= {high_sync[0], supply_high_threshold};
		end
	end

	wire supply_low = low_sync[1];
	wire supply_high = high_sync[1];

	// ************************************************
	// cycle accumulation
	// ************************************************
	logic [23:0] smp_cnt;
	logic signed [PACC_W-1:0] p_acc;
	logic [SQACC_W-1:0] i_acc;
	logic [SQACC_W-1:0] v_acc;
	logic signed [PACC_W-1:0] p_snap;
	logic [SQACC_W-1:0] i_snap;
	logic [SQACC_W-1:0] v_snap;

	// a zero count would never end a cycle, so it behaves as one
	wire [23:0] n_eff = (cycle_count == 24'h000000) ? 24'h000001 : cycle_count;
	wire take = sample.valid && conversions_on;
	wire cycle_end = take && (smp_cnt == n_eff - 24'h000001);
	wire signed [PACC_W-1:0] p_term = PACC_W'($signed(sample.power)) + PACC_W'($signed(power_bias));
	wire signed [47:0] i_sq = $signed(sample.current) * $signed(sample.current);
	wire signed [47:0] v_sq = $signed(sample.voltage) * $signed(sample.voltage);
	wire [SQACC_W-1:0] i_term = SQACC_W'(i_sq[46:0]);
	wire [SQACC_W-1:0] v_term = SQACC_W'(v_sq[46:0]);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			smp_cnt <= 24'h000000;
			p_acc <= '0;
			i_acc <= '0;
			v_acc <= '0;
			p_snap <= '0;
			i_snap <= '0;
			v_snap <= '0;
		end
		else if (!conversions_on)
		begin
			smp_cnt <= 24'h000000;
			p_acc <= '0;
			i_acc <= '0;
			v_acc <= '0;
		end
		else if (cycle_end)
		begin
			smp_cnt <= 24'h000000;
			p_snap <= p_acc + p_term;
			i_snap <= i_acc + i_term;
			v_snap <= v_acc + v_term;
			p_acc <= '0;
			i_acc <= '0;
			v_acc <= '0;
		end
		else if (take)
		begin
			smp_cnt <= smp_cnt + 24'h000001;
			p_acc <= p_acc + p_term;
			i_acc <= i_acc + i_term;
			v_acc <= v_acc + v_term;
		end
	end

	// ************************************************
	// mean and root engine
	// ************************************************
	// one shared serial divider and root: about 265 cycles per computation cycle
	msrr_state_e state;
	logic [6:0] step;
	logic [DIV_W-1:0] div_num;
	logic [23:0] div_rem;
	logic p_neg;
	logic [MS_W-1:0] sq_rad;
	logic [25:0] sq_rem;
	logic [23:0] sq_root;
	logic ovf_pow;
	logic ovf_current_rms_result;
	logic ovf_voltage_rms_result;
	logic cycle_done;
	// snapshot lands on the cycle end edge, so the engine starts one edge later
	logic snap_ready;

	wire [24:0] div_sh = {div_rem, div_num[DIV_W-1]};
	wire [25:0] div_sub = {1'b0, div_sh} - {2'h0, n_eff};
	wire div_ge = !div_sub[25];
	wire [DIV_W-1:0] div_q = {div_num[DIV_W-2:0], div_ge};
	wire [27:0] sq_sh = {sq_rem, sq_rad[MS_W-1:MS_W-2]};
	wire [28:0] sq_sub = {1'b0, sq_sh} - {3'h0, sq_root, 2'h1};
	wire sq_ge = !sq_sub[28];
	wire [23:0] sq_next = {sq_root[22:0], sq_ge};
	wire last = (step == 7'h01);
	wire [PACC_W-1:0] p_mag = p_snap[PACC_W-1] ? PACC_W'(-p_snap) : PACC_W'(p_snap);
	// quotient beyond 24 signed bits saturates and raises the overflow flag
	wire p_hi = p_neg ? (div_q > DIV_W'(24'h800000)) : (div_q > DIV_W'(24'h7FFFFF));
	wire [23:0] p_pos = p_neg ? 24'h800000 : 24'h7FFFFF;
	wire [23:0] p_res = p_hi ? p_pos : (p_neg ? 24'(-div_q[23:0]) : div_q[23:0]);
	wire ms_hi = |div_q[DIV_W-1:MS_W-2];
	wire [MS_W-1:0] ms_val = ms_hi ? {MS_W{1'b1}} : {div_q[MS_W-3:0], 2'h0};

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= ST_IDLE;
			step <= 7'h00;
			div_num <= '0;
			div_rem <= 24'h000000;
			p_neg <= 1'b0;
			sq_rad <= '0;
			sq_rem <= 26'h0;
			sq_root <= 24'h000000;
			ovf_pow <= 1'b0;
			ovf_current_rms_result <= 1'b0;
			ovf_voltage_rms_result <= 1'b0;
			cycle_done <= 1'b0;
			snap_ready <= 1'b0;
			averaged_power <= 24'h000000;
			current_root_mean_square <= 24'h000000;
			voltage_root_mean_square <= 24'h000000;
		end
		else
		begin
			ovf_pow <= 1'b0;
			ovf_current_rms_result <= 1'b0;
			ovf_voltage_rms_result <= 1'b0;
			cycle_done <= 1'b0;
			snap_ready <= cycle_end;
			if (state != ST_IDLE)
				step <= step - 7'h01;
			if (state == ST_P_DIV || state == ST_I_DIV || state == ST_V_DIV)
			begin
				div_num <= div_q;
				div_rem <= div_ge ? div_sub[23:0] : div_sh[23:0];
			end
			if (state == ST_I_SQRT || state == ST_V_SQRT)
			begin
				sq_rad <= {sq_rad[MS_W-3:0], 2'h0};
				sq_rem <= sq_ge ? sq_sub[25:0] : sq_sh[25:0];
				sq_root <= sq_next;
			end
			unique case (state)
				ST_IDLE:
					if (snap_ready)
					begin
						state <= ST_P_DIV;
						step <= DIV_STEPS;
						div_rem <= 24'h000000;
						div_num <= DIV_W'(p_mag);
						p_neg <= p_snap[PACC_W-1];
					end
				ST_P_DIV:
					if (last)
					begin
						averaged_power <= p_res;
						ovf_pow <= p_hi;
						state <= ST_I_DIV;
						step <= DIV_STEPS;
						div_rem <= 24'h000000;
						div_num <= DIV_W'(i_snap);
					end
				ST_I_DIV, ST_V_DIV:
					if (last)
					begin
						if (state == ST_I_DIV)
							ovf_current_rms_result <= ms_hi;
						else
							ovf_voltage_rms_result <= ms_hi;
						state <= (state == ST_I_DIV) ? ST_I_SQRT : ST_V_SQRT;
						step <= SQRT_STEPS;
						sq_rad <= ms_val;
						sq_rem <= 26'h0;
						sq_root <= 24'h000000;
					end
				ST_I_SQRT:
					if (last)
					begin
						current_root_mean_square <= sq_next;
						state <= ST_V_DIV;
						step <= DIV_STEPS;
						div_rem <= 24'h000000;
						div_num <= DIV_W'(v_snap);
					end
				ST_V_SQRT:
					if (last)
					begin
						voltage_root_mean_square <= sq_next;
						cycle_done <= conversions_on;
						state <= ST_IDLE;
					end
			endcase
		end
	end

	// ************************************************
	// event flags
	// ************************************************
	logic [23:0] set_vec;
	always_comb
	begin
		set_vec = 24'h000000;
		set_vec[BIT_CYCLE_DONE] = cycle_done || calibration_done;
		set_vec[BIT_SAMPLE_DONE] = sample.valid;
		set_vec[BIT_I_INST_OVF] = current_inst_overflow;
		set_vec[BIT_V_INST_OVF] = voltage_inst_overflow;
		set_vec[BIT_I_RMS_OVF] = ovf_current_rms_result;
		set_vec[BIT_V_RMS_OVF] = ovf_voltage_rms_result;
		set_vec[BIT_POWER_OVF] = ovf_pow;
		set_vec[BIT_TEMP_NEW] = temperature_update;
		// levels are sampled every cycle, so a held overload reappears at once after a clear
		set_vec[BIT_TEMP_OSC] = temp_modulator_oscillation;
		set_vec[BIT_V_OSC] = voltage_modulator_oscillation;
		set_vec[BIT_I_OSC] = current_modulator_oscillation;
		set_vec[BIT_SUPPLY_LOW] = supply_low;
		set_vec[BIT_VOLTAGE_DIP] = voltage_dip_event;
	end

	wire [23:0] clr_raw = wr_flags ? (reg_wdata & FLAG_IMPL_MASK) : 24'h000000;
	wire [23:0] clr_hold = supply_rearmed ? 24'h000000 : (24'h000001 << BIT_SUPPLY_LOW);
	wire [23:0] clr_vec = clr_raw & ~clr_hold;
	wire ic_fault = bad_command || status_read_fail;
	wire [23:0] next_flags_raw = (event_flags & ~clr_vec) | set_vec;
	wire ic_next = ic_fault ? 1'b0 : (clr_vec[BIT_BAD_COMMAND_N] | event_flags[BIT_BAD_COMMAND_N]);
	wire [23:0] next_flags = {next_flags_raw[23:1], ic_next} & FLAG_IMPL_MASK;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			event_flags <= RST_EVENT_FLAGS;
			supply_rearmed <= 1'b0;
		end
		else
		begin
			event_flags <= next_flags;
			if (supply_low)
				supply_rearmed <= 1'b0;
			else if (supply_high)
				supply_rearmed <= 1'b1;
		end
	end

	// ************************************************
	// interrupt pin
	// ************************************************
	logic irq_last;
	logic [3:0] pulse_cnt;
	wire irq_active = |((event_flags ^ FLAG_LOW_ACTIVE) & event_enable);
	wire pulse_on = (pulse_cnt != 4'h0);
	logic next_pin;
	always_comb
	begin
		unique case (irq_style_sel)
			IRQ_LEVEL_LOW: next_pin = !irq_active;
			IRQ_LEVEL_HIGH: next_pin = irq_active;
			IRQ_PULSE_FALL: next_pin = !pulse_on;
			IRQ_PULSE_RISE: next_pin = pulse_on;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			irq_last <= 1'b0;
			pulse_cnt <= 4'h0;
			irq_pin <= 1'b1;
		end
		else
		begin
			irq_last <= irq_active;
			if (irq_active && !irq_last)
				pulse_cnt <= IRQ_PULSE_CYCLES;
			else if (pulse_on)
				pulse_cnt <= pulse_cnt - 4'h1;
			irq_pin <= next_pin;
		end
	end

endmodule

/* File: tb/msrr_chk.sv */
// checker: port-level timing and decode relations of the status and result registers
// assumes it is bound to the top module; one clock domain
`timescale 1ns/1ps
module msrr_chk
	import msrr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire msrr_sample_s sample,
	input wire logic voltage_modulator_oscillation,
	input wire logic bad_command,
	input wire logic [1:0] irq_style_sel,
	input wire logic irq_pin,
	input wire logic [DATA_W-1:0] averaged_power
);
	// ****
	// enable shadow, rebuilt from host writes
	// ****
	logic [23:0] en;
	wire en_wr = reg_wr && reg_addr == ADDR_EVENT_ENABLE;
	wire rd_f = reg_addr == ADDR_EVENT_FLAGS;
	wire [23:0] next_en = en_wr ? (reg_wdata & FLAG_IMPL_MASK) : en;
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			en <= 24'h000000;
		else
			en <= next_en;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// ****
	// relations
	// ****
	property p_avg;
		reg_addr == ADDR_AVG_POWER |=> reg_rdata == $past(averaged_power);
	endproperty
	a_avg: assert property (p_avg) else $error("result read mismatch");
	property p_hole;
		!(reg_addr inside {5'h05, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h1A}) |=> reg_rdata == 24'h000000;
	endproperty
	a_hole: assert property (p_hole) else $error("unmapped read not zero");
	property p_conv;
		sample.valid && rd_f ##1 rd_f |=> reg_rdata[BIT_SAMPLE_DONE];
	endproperty
	a_conv: assert property (p_conv) else $error("sample flag missing");
	property p_osc;
		voltage_modulator_oscillation && rd_f ##1 rd_f |=> reg_rdata[BIT_V_OSC];
	endproperty
	a_osc: assert property (p_osc) else $error("oscillation flag missing");
	property p_bad;
		bad_command && rd_f ##1 rd_f |=> !reg_rdata[BIT_BAD_COMMAND_N];
	endproperty
	a_bad: assert property (p_bad) else $error("bad command bit high");
	property p_en;
		en_wr ##1 reg_addr == ADDR_EVENT_ENABLE |=> reg_rdata == $past(en);
	endproperty
	a_en: assert property (p_en) else $error("enable readback wrong");
	// pin and read data both come from the flags of the same cycle
	property p_irq_low;
		$past(rstn) && $past(rd_f) && $past(irq_style_sel) == IRQ_LEVEL_LOW
			|-> irq_pin == !(|((reg_rdata ^ FLAG_LOW_ACTIVE) & $past(en)));
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("low level pin wrong");
	property p_irq_high;
		$past(rstn) && $past(rd_f) && $past(irq_style_sel) == IRQ_LEVEL_HIGH
			|-> irq_pin == (|((reg_rdata ^ FLAG_LOW_ACTIVE) & $past(en)));
	endproperty
	a_irq_high: assert property (p_irq_high) else $error("high level pin wrong");
	property p_pulse;
		$past(irq_style_sel) == IRQ_PULSE_FALL && $fell(irq_pin) |-> !irq_pin[*8] ##1 irq_pin;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse width wrong");
	c_conv: cover property (sample.valid && rd_f);
	c_bad: cover property (bad_command);
	c_pulse: cover property ($fell(irq_pin) && irq_style_sel == IRQ_PULSE_FALL);
endmodule

/* File: tb/msrr_host_model.sv */
// host model: drives the register port, one access at a time
// assumes requests launch just after a rising core_clk edge
`timescale 1ns/1ps
module msrr_host_model
	import msrr_pkg::*;
(
	input wire logic core_clk,
	input wire logic [DATA_W-1:0] reg_rdata,
	output logic [ADDR_W-1:0] reg_addr,
	output logic reg_wr,
	output logic [DATA_W-1:0] reg_wdata
);
	initial
	begin
		reg_addr = 5'h00;
		reg_wr = 1'b0;
		reg_wdata = 24'h000000;
	end
	// released data inverted so a stale word never passes for a fresh one
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wr = 1'b1;
		reg_wdata = d;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [23:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		@(posedge core_clk);
		#1;
		d = reg_rdata;
	endtask
endmodule

/* File: tb/msrr_meter_status_result_regs_tb.sv */
// bench: table of register cases, then flag, interrupt and result tests
// assumes checker and host model compiled first; 100 MHz core clock
`timescale 1ns/1ps
module msrr_meter_status_result_regs_tb
	import msrr_pkg::*;
;
	typedef struct packed {logic w; logic [4:0] a; logic [23:0] d; logic [23:0] e;} msrr_row_s;
	logic core_clk;
	logic rstn;
	logic [ADDR_W-1:0] reg_addr;
	logic reg_wr;
	logic [DATA_W-1:0] reg_wdata;
	logic [DATA_W-1:0] reg_rdata;
	msrr_sample_s sample;
	logic conversions_on;
	logic [9:0] ev;
	logic sup_lo;
	logic sup_hi;
	logic [1:0] irq_style_sel;
	logic irq_pin;
	logic [DATA_W-1:0] averaged_power;
	logic [DATA_W-1:0] i_rms;
	logic [DATA_W-1:0] v_rms;
	int miscompares = 0;
	int samples_checked = 0;
	int n;
	int pos[8] = '{BIT_CYCLE_DONE, BIT_TEMP_NEW, BIT_I_INST_OVF, BIT_V_INST_OVF, BIT_TEMP_OSC, BIT_V_OSC,
		BIT_I_OSC, BIT_VOLTAGE_DIP};
	msrr_row_s rows[13] = '{
		'{1'b0, ADDR_CYCLE_COUNT, 24'h000000, RST_CYCLE_COUNT},
		'{1'b0, ADDR_POWER_BIAS, 24'h000000, RST_POWER_BIAS},
		'{1'b0, ADDR_EVENT_FLAGS, 24'h000000, RST_EVENT_FLAGS},
		'{1'b0, ADDR_EVENT_ENABLE, 24'h000000, RST_EVENT_ENABLE},
		'{1'b0, ADDR_AVG_POWER, 24'h000000, 24'h000000},
		'{1'b0, ADDR_I_RMS, 24'h000000, 24'h000000},
		'{1'b0, ADDR_V_RMS, 24'h000000, 24'h000000},
		'{1'b1, 5'h03, 24'hABCDEF, 24'h000000},
		'{1'b1, ADDR_AVG_POWER, 24'h7FFFFF, 24'h000000},
		'{1'b1, ADDR_EVENT_ENABLE, 24'hFFFFFF, FLAG_IMPL_MASK},
		'{1'b1, ADDR_EVENT_ENABLE, 24'h000000, 24'h000000},
		'{1'b1, ADDR_POWER_BIAS, 24'h000004, 24'h000004},
		'{1'b1, ADDR_CYCLE_COUNT, 24'h000002, 24'h000002}};
	msrr_meter_status_result_regs msrr_meter_status_result_regs_inst (
		.core_clk, .rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .sample, .conversions_on,
		.calibration_done(ev[0]), .temperature_update(ev[1]), .current_inst_overflow(ev[2]),
		.voltage_inst_overflow(ev[3]), .temp_modulator_oscillation(ev[4]), .voltage_modulator_oscillation(ev[5]),
		.current_modulator_oscillation(ev[6]), .voltage_dip_event(ev[7]), .bad_command(ev[8]),
		.status_read_fail(ev[9]), .supply_low_threshold(sup_lo), .supply_high_threshold(sup_hi), .irq_style_sel,
		.irq_pin, .averaged_power, .current_root_mean_square(i_rms), .voltage_root_mean_square(v_rms));
	msrr_host_model msrr_host_model_inst (.core_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata);
	// ****
	// helpers
	// ****
	task automatic tick(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask
	task automatic drive(input logic [9:0] v);
		tick(1);
		ev = v;
		tick(1);
		ev = 10'h000;
	endtask
	task automatic send(input logic [23:0] i, input logic [23:0] v, input logic [23:0] p);
		tick(1);
		sample = '{1'b1, i, v, p};
		tick(1);
		sample = '{1'b0, ~i, ~v, ~p};
	endtask
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		msrr_host_model_inst.wr(a, d);
	endtask
	task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rdchk(input string s, input logic [4:0] a, input logic [23:0] e);
		logic [23:0] d;
		msrr_host_model_inst.rd(a, d);
		chk(s, e, d);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ****
	// clock, watchdog, sequence
	// ****
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		#200000;
		miscompares++;
		test_done();
	end
	initial
	begin
		rstn = 1'b0;
		ev = 10'h000;
		sup_lo = 1'b0;
		sup_hi = 1'b0;
		irq_style_sel = IRQ_LEVEL_LOW;
		conversions_on = 1'b1;
		sample = 73'h0;
		tick(4);
		chk("irq in reset", 24'h000001, {23'h000000, irq_pin});
		rstn = 1'b1;
		foreach (rows[i])
		begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rdchk($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].e);
		end
		foreach (pos[i])
		begin
			drive(10'h001 << i);
			rdchk("flag set", ADDR_EVENT_FLAGS, (24'h000001 << pos[i]) | 24'h000001);
			wr(ADDR_EVENT_FLAGS, 24'hFFFFFF);
			rdchk("flag clear", ADDR_EVENT_FLAGS, 24'h000001);
		end
		drive(10'h082);
		wr(ADDR_EVENT_FLAGS, 24'h000080);
		rdchk("partial clear", ADDR_EVENT_FLAGS, 24'h000003);
		ev[5] = 1'b1;
		wr(ADDR_EVENT_FLAGS, 24'h000010);
		rdchk("overload kept", ADDR_EVENT_FLAGS, 24'h000013);
		ev[5] = 1'b0;
		wr(ADDR_EVENT_FLAGS, 24'hFFFFFF);
		// supply inputs pass a two-stage synchronizer, hence the waits
		sup_lo = 1'b1;
		tick(4);
		sup_lo = 1'b0;
		tick(4);
		wr(ADDR_EVENT_FLAGS, 24'h000004);
		rdchk("low supply held", ADDR_EVENT_FLAGS, 24'h000005);
		sup_hi = 1'b1;
		tick(4);
		wr(ADDR_EVENT_FLAGS, 24'h000004);
		rdchk("low supply freed", ADDR_EVENT_FLAGS, 24'h000001);
		sup_hi = 1'b0;
		for (int i = 8; i < 10; i++)
		begin
			drive(10'h001 << i);
			rdchk("fault", ADDR_EVENT_FLAGS, 24'h000000);
			wr(ADDR_EVENT_FLAGS, 24'h000001);
			rdchk("fault mended", ADDR_EVENT_FLAGS, 24'h000001);
		end
		wr(ADDR_EVENT_ENABLE, 24'h000040);
		drive(10'h002);
		tick(3);
		chk("masked pin", 24'h000001, {23'h000000, irq_pin});
		wr(ADDR_EVENT_ENABLE, 24'h000080);
		tick(3);
		chk("low pin", 24'h000000, {23'h000000, irq_pin});
		irq_style_sel = IRQ_LEVEL_HIGH;
		tick(3);
		chk("high pin", 24'h000001, {23'h000000, irq_pin});
		wr(ADDR_EVENT_FLAGS, 24'h000080);
		tick(3);
		chk("high pin idle", 24'h000000, {23'h000000, irq_pin});
		for (int s = 2; s < 4; s++)
		begin
			irq_style_sel = 2'(s);
			tick(3);
			drive(10'h002);
			n = 0;
			repeat (20)
			begin
				tick(1);
				n += (irq_pin == (s == 3));
			end
			chk("pulse cycles", {20'h00000, IRQ_PULSE_CYCLES}, 24'(n));
			wr(ADDR_EVENT_FLAGS, 24'h000080);
		end
		irq_style_sel = IRQ_LEVEL_LOW;
		wr(ADDR_EVENT_FLAGS, 24'hFFFFFF);
		// two samples per cycle; bias 4 added to each power sample
		send(24'h400000, 24'h200000, 24'h100000);
		send(24'h400000, 24'h200000, 24'h100002);
		tick(300);
		chk("mean power", 24'h100005, averaged_power);
		chk("current rms", 24'h800000, i_rms);
		chk("voltage rms", 24'h400000, v_rms);
		rdchk("power reg", ADDR_AVG_POWER, 24'h100005);
		rdchk("cycle flags", ADDR_EVENT_FLAGS, 24'h900001);
		wr(ADDR_EVENT_FLAGS, 24'hFFFFFF);
		send(24'h800000, 24'h800000, 24'h7FFFFE);
		send(24'h800000, 24'h800000, 24'h7FFFFE);
		tick(300);
		chk("power clamp", 24'h7FFFFF, averaged_power);
		rdchk("overflow flags", ADDR_EVENT_FLAGS, 24'h907001);
		// a sample taken while conversions are off must not count toward the cycle
		wr(ADDR_EVENT_FLAGS, 24'hFFFFFF);
		conversions_on = 1'b0;
		send(24'h100000, 24'h100000, 24'h100000);
		conversions_on = 1'b1;
		send(24'h100000, 24'h100000, 24'h100000);
		tick(300);
		rdchk("no cycle end", ADDR_EVENT_FLAGS, 24'h100001);
		// second reset in mid-run, enable and flags were left non-default
		rstn = 1'b0;
		tick(2);
		rstn = 1'b1;
		rdchk("enable after reset", ADDR_EVENT_ENABLE, RST_EVENT_ENABLE);
		rdchk("flags after reset", ADDR_EVENT_FLAGS, RST_EVENT_FLAGS);
		test_done();
	end
endmodule
bind msrr_meter_status_result_regs msrr_chk msrr_chk_inst (.core_clk, .rstn, .reg_addr, .reg_wr, .reg_wdata,
	.reg_rdata, .sample, .voltage_modulator_oscillation, .bad_command, .irq_style_sel, .irq_pin, .averaged_power);
